// File: rtl/spbt_serial_port.v
`include "spbt_defines.vh"
`default_nettype none
// How it works
// - One-bit clocked serial in and out.
// - Device drives both user bit clocks.
// - No user bit when framed: send empty-frame filler.
// - Test sequence may replace user data.
// - Sequence is 2047-bit, eleven-stage register.
// - Sync high while aligned with sequence.
// - Byte-error flag, meaningful only when synced.
// - Start pulse every 2047 bits, under 10%.
// - Count errors over million-bit window, 32-bit.
// - Count updates per window; reads do not clear.
module spbt_serial_port #(
  parameter integer TX_HALF    = `SPBT_TX_HALF,
  parameter integer RX_HALF    = `SPBT_RX_HALF,
  parameter integer BER_WINDOW = `SPBT_BER_WINDOW
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_frame_en,
  input  wire        i_prbs_tx_en,
  input  wire        i_tx_data,
  input  wire        i_tx_data_valid,
  output reg         o_tx_clk,
  output reg         o_mod_valid,
  output reg         o_mod_bit,
  output reg         o_mod_idle,
  input  wire        i_mod_ready,
  input  wire        i_dem_valid,
  input  wire        i_dem_bit,
  output reg         o_rx_clk,
  output reg         o_rx_data,
  output reg         o_sync,
  output reg         o_byte_err,
  output reg         o_seq_start,
  output reg  [31:0] o_err_count
);
  // Three-stage synchronisers for the user pins.
  reg  [2:0]  data_sync;
  reg  [2:0]  valid_sync;
  // Filtered user levels, updated once stages two and three agree.
  reg         user_bit;
  reg         user_valid;
  // Transmit bit-clock divider.
  reg  [15:0] tx_cnt;
  // Second buffer entry: a skid slot holding {idle, bit}.
  reg         skid_valid;
  reg         skid_bit;
  reg         skid_idle;
  // Push request toward the buffer and its contents.
  reg         push;
  reg         push_bit;
  reg         push_idle;
  // Generator step and output.
  reg         prbs_step;
  wire        prbs_bit;
  // Receive bit-clock divider and held demodulated bit.
  reg  [15:0] rx_cnt;
  reg         rx_hold;
  // Checker history, newest bit in stage zero.
  reg  [10:0] hist;
  reg  [3:0]  hist_fill;
  // Sync window counters.
  reg  [8:0]  sync_bits;
  reg  [8:0]  sync_errs;
  // Byte error tracking.
  reg  [2:0]  byte_pos;
  reg         byte_bad;
  // Error-rate window counters.
  reg  [19:0] win_bits;
  reg  [31:0] win_errs;
  // Predicted bit and mismatch for the current received bit.
  wire        pred;
  wire        bit_err;
  wire        pop;
  wire        tx_rise;
  wire        rx_fall;

  // Predicts the next sequence bit from the received history.
  function next_bit;
    input [10:0] h;
    begin
      next_bit = h[`SPBT_TAP_A] ^ h[`SPBT_TAP_B];
    end
  endfunction

  assign pred    = next_bit(hist);
  assign bit_err = (hist_fill == 4'hB) && (pred != i_dem_bit);
  assign pop     = o_mod_valid & i_mod_ready;
  // The rising edge is held back while the buffer is full, so the user
  // simply sees a stretched clock and no bit is ever dropped.
  assign tx_rise = !o_tx_clk && (tx_cnt == TX_HALF[15:0] - 16'h0001) && !skid_valid;
  assign rx_fall = o_rx_clk && (rx_cnt == RX_HALF[15:0] - 16'h0001);

  spbt_prbs11 u_gen (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_step     (prbs_step),
    .o_bit      (prbs_bit)
  );

  // Synchronise user pins; a change counts once the last two stages agree.
  // The chain runs on through reset, so the first bit clock after release
  // already sees the settled pin levels rather than a reset value.
  always @(posedge i_core_clk) begin
    data_sync  <= {data_sync[1:0], i_tx_data};
    valid_sync <= {valid_sync[1:0], i_tx_data_valid};
    if (data_sync[2] == data_sync[1]) begin
      user_bit <= data_sync[2];
    end
    if (valid_sync[2] == valid_sync[1]) begin
      user_valid <= valid_sync[2];
    end
  end

  // Transmit clock generator driven out to the user source.
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      tx_cnt   <= 16'h0000;
      o_tx_clk <= 1'b0;
    end else if (tx_cnt == TX_HALF[15:0] - 16'h0001) begin
      if (o_tx_clk || !skid_valid) begin
        o_tx_clk <= !o_tx_clk;
        tx_cnt   <= 16'h0000;
      end
    end else begin
      tx_cnt <= tx_cnt + 16'h0001;
    end
  end

  // Chooses what enters the modulator path at each rising edge.
  always @* begin
    push      = 1'b0;
    push_bit  = 1'b0;
    push_idle = 1'b0;
    prbs_step = 1'b0;
    if (tx_rise) begin
      push = 1'b1;
      if (i_prbs_tx_en) begin
        prbs_step = 1'b1;
        push_bit  = prbs_bit;
      end else if (i_frame_en && !user_valid) begin
        push_idle = 1'b1;
      end else begin
        push_bit = user_bit;
      end
    end
  end

  // Two-entry buffer: head drives the outputs, skid absorbs a stall.
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_mod_valid <= 1'b0;
      o_mod_bit   <= 1'b0;
      o_mod_idle  <= 1'b0;
      skid_valid  <= 1'b0;
      skid_bit    <= 1'b0;
      skid_idle   <= 1'b0;
    end else if (pop) begin
      if (skid_valid) begin
        o_mod_bit  <= skid_bit;
        o_mod_idle <= skid_idle;
        skid_valid <= push;
        skid_bit   <= push_bit;
        skid_idle  <= push_idle;
      end else begin
        o_mod_valid <= push;
        o_mod_bit   <= push_bit;
        o_mod_idle  <= push_idle;
      end
    end else if (push) begin
      if (!o_mod_valid) begin
        o_mod_valid <= 1'b1;
        o_mod_bit   <= push_bit;
        o_mod_idle  <= push_idle;
      end else begin
        skid_valid <= 1'b1;
        skid_bit   <= push_bit;
        skid_idle  <= push_idle;
      end
    end
  end

  // Receive clock and data toward the user sink.
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rx_cnt    <= 16'h0000;
      o_rx_clk  <= 1'b0;
      rx_hold   <= 1'b0;
      o_rx_data <= 1'b0;
    end else begin
      if (i_dem_valid) begin
        rx_hold <= i_dem_bit;
      end
      if (rx_cnt == RX_HALF[15:0] - 16'h0001) begin
        o_rx_clk <= !o_rx_clk;
        rx_cnt   <= 16'h0000;
      end else begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
      if (rx_fall) begin
        o_rx_data <= rx_hold;
      end
    end
  end

  // Self-aligning checker: each bit is predicted from the eleven before it.
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      hist        <= 11'h000;
      hist_fill   <= 4'h0;
      sync_bits   <= 9'h000;
      sync_errs   <= 9'h000;
      o_sync      <= 1'b0;
      byte_pos    <= 3'h0;
      byte_bad    <= 1'b0;
      o_byte_err  <= 1'b0;
      o_seq_start <= 1'b0;
      win_bits    <= 20'h00000;
      win_errs    <= 32'h00000000;
      o_err_count <= 32'h00000000;
    end else begin
      o_byte_err  <= 1'b0;
      o_seq_start <= 1'b0;
      if (i_dem_valid) begin
        hist <= {hist[9:0], i_dem_bit};
        if (hist_fill != 4'hB) begin
          hist_fill <= hist_fill + 4'h1;
        end
        if (sync_bits == `SPBT_SYNC_WINDOW - 1) begin
          o_sync    <= (sync_errs + {8'h00, bit_err}) < `SPBT_SYNC_LIMIT;
          sync_bits <= 9'h000;
          sync_errs <= 9'h000;
        end else begin
          sync_bits <= sync_bits + 9'h001;
          sync_errs <= sync_errs + {8'h00, bit_err};
        end
        byte_pos <= byte_pos + 3'h1;
        if (byte_pos == 3'h7) begin
          o_byte_err <= o_sync && (byte_bad || bit_err);
          byte_bad   <= 1'b0;
        end else begin
          byte_bad <= byte_bad || bit_err;
        end
        if (o_sync && ({hist[9:0], i_dem_bit} == `SPBT_PRBS_SEED)) begin
          o_seq_start <= 1'b1;
        end
        if (win_bits == BER_WINDOW[19:0] - 20'h00001) begin
          o_err_count <= win_errs + {31'h00000000, bit_err};
          win_errs    <= 32'h00000000;
          win_bits    <= 20'h00000;
        end else begin
          win_errs <= win_errs + {31'h00000000, bit_err};
          win_bits <= win_bits + 20'h00001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/spbt_defines.vh
`ifndef SPBT_DEFINES_VH
`define SPBT_DEFINES_VH
// Test sequence register length and period.
`define SPBT_PRBS_LEN      11
`define SPBT_PRBS_PERIOD   2047
// Start state of the sequence, all stages set.
`define SPBT_PRBS_SEED     11'h7FF
// Feedback taps for x^11 + x^9 + 1 (stage indices).
`define SPBT_TAP_A         10
`define SPBT_TAP_B         8
// Error-rate measurement window in bits.
`define SPBT_BER_WINDOW    1000000
// Synchronisation window and its 10% error limit.
`define SPBT_SYNC_WINDOW   256
`define SPBT_SYNC_LIMIT    25
// Core clock period in ns and default link bit-clock periods in ns.
`define SPBT_CORE_NS       20
`define SPBT_TX_BIT_NS     160
`define SPBT_RX_BIT_NS     160
// Half-period counts of the generated bit clocks, in core cycles.
`define SPBT_TX_HALF       ((`SPBT_TX_BIT_NS / 2) / `SPBT_CORE_NS)
`define SPBT_RX_HALF       ((`SPBT_RX_BIT_NS / 2) / `SPBT_CORE_NS)
`endif

// File: rtl/spbt_prbs11.v
`include "spbt_defines.vh"
`default_nettype none
// Free-standing 11-stage maximal-length generator; steps once per enable.
module spbt_prbs11 (
  input  wire i_core_clk,
  input  wire i_nrst,
  input  wire i_step,
  output reg  o_bit
);
  // Shift register state, never all zero.
  reg [`SPBT_PRBS_LEN-1:0] state;
  // Feedback bit of the current state.
  wire                     fb;
  // Seed state and the first bit that it yields.
  localparam [`SPBT_PRBS_LEN-1:0] SEED    = `SPBT_PRBS_SEED;
  localparam [0:0]                SEED_FB = SEED[`SPBT_TAP_A] ^ SEED[`SPBT_TAP_B];

  assign fb = state[`SPBT_TAP_A] ^ state[`SPBT_TAP_B];

  // Each step shifts the feedback in and loads the output with the feedback of the next step.
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state <= SEED;
      o_bit <= SEED_FB;
    end else if (i_step) begin
      state <= {state[`SPBT_PRBS_LEN-2:0], fb};
      // The output runs one step ahead: it is the bit that the next step yields,
      // so a caller that steps and reads in one cycle gets that step's bit.
      o_bit <= state[`SPBT_TAP_A-1] ^ state[`SPBT_TAP_B-1];
    end
  end
endmodule
`default_nettype wire

// File: bench/spbt_serial_port_assertions.sv
`default_nettype none
module spbt_sva (
  input wire logic        i_core_clk, i_nrst, i_mod_ready, i_dem_valid,
  input wire logic        o_tx_clk, o_mod_valid, o_mod_bit, o_mod_idle,
  input wire logic        o_rx_clk, o_rx_data, o_sync, o_byte_err, o_seq_start,
  input wire logic [31:0] o_err_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so the clock and the reset are declared once.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_head_held: assert property (
    o_mod_valid && !i_mod_ready |=> o_mod_valid && $stable({o_mod_bit, o_mod_idle}))
    else $error("head moved while stalled");
  a_tx_high: assert property (
    $rose(o_tx_clk) |-> o_mod_valid ##0 o_tx_clk [*4] ##1 !o_tx_clk)
    else $error("tx clock high phase wrong");
  a_rx_high: assert property (
    $rose(o_rx_clk) |-> o_rx_clk [*4] ##1 !o_rx_clk) else $error("rx clock high phase wrong");
  a_rx_edge: assert property (
    $changed(o_rx_data) |-> $fell(o_rx_clk)) else $error("rx data moved off falling edge");
  a_err_synced: assert property (
    o_byte_err |-> (o_sync || $past(o_sync)) ##1 !o_byte_err [*7])
    else $error("byte error unsynced or long");
  a_start_gap: assert property (
    o_seq_start |-> (o_sync || $past(o_sync)) ##1 !o_seq_start [*8])
    else $error("start pulse unsynced or long");
  a_count_step: assert property (
    $changed(o_err_count) |-> $past(i_dem_valid) || $past(i_dem_valid, 2))
    else $error("error count moved without a bit");
  a_sync_step: assert property (
    $changed(o_sync) |-> $past(i_dem_valid) || $past(i_dem_valid, 2))
    else $error("sync moved without a bit");
endmodule
bind spbt_serial_port spbt_sva u_sva (.i_core_clk, .i_nrst, .i_mod_ready, .i_dem_valid,
  .o_tx_clk, .o_mod_valid, .o_mod_bit, .o_mod_idle, .o_rx_clk, .o_rx_data, .o_sync,
  .o_byte_err, .o_seq_start, .o_err_count);
`default_nettype wire

// File: bench/spbt_user_model.sv
`default_nettype none
module spbt_user_model (
  input  wire logic i_core_clk, i_nrst, i_frame_en, i_tx_clk,
  output var  logic o_tx_data = 1'b0,
  output var  logic o_tx_data_valid = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  int   seed = 58011;
  int   q[$];         // Slots taken by the modem; 2 marks a withheld slot.
  logic pc   = 1'b0;  // Bit clock seen at the last falling core edge.
  // Sampled at the falling core edge. The next bit is launched just after each
  // rise, a full bit period ahead, so it clears the modem's pin synchroniser.
  always @(negedge i_core_clk) begin
    if (!i_nrst) begin
      q.delete();
    end else if (i_tx_clk && !pc) begin
      // one slot per rise, then a fresh bit.
      q.push_back(i_frame_en && !o_tx_data_valid ? 2 : o_tx_data);
      o_tx_data <= 1'($random(seed));
      // framed source sometimes withholds its bit.
      o_tx_data_valid <= !i_frame_en || $random(seed) % 3 != 0;
    end
    pc <= i_tx_clk;
  end
endmodule
`default_nettype wire

// File: bench/spbt_serial_port_test.sv
`default_nettype none
module spbt_serial_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0, i_nrst = 1'b0, i_frame_en = 1'b0, i_prbs_tx_en = 1'b0;
  logic i_mod_ready = 1'b1, i_dem_valid = 1'b0, i_dem_bit = 1'b0, stall = 1'b0;
  logic acc = 1'b0, lb = 1'b0, e, berr = 1'b0, prx = 1'b0, rxh = 1'b0, rxe = 1'b0;
  logic [10:0] gen, hist;
  wire logic tx_d, tx_v, o_tx_clk, o_mod_valid, o_mod_bit, o_mod_idle;
  wire logic o_rx_clk, o_rx_data, o_sync, o_byte_err, o_seq_start;
  wire logic [31:0] o_err_count;
  int seed = 58011, miscompares = 0, n_checks = 0, cycles = 0, ntx = 0, v;
  int nbits = 0, nerr = 0, wcnt = 0, due = 0, nbyte = 0, nstart = 0, gbyte = 0, gstart = 0;
  // A short error window keeps the run small.
  spbt_serial_port #(.BER_WINDOW(1000)) uut (.i_core_clk, .i_nrst, .i_frame_en,
    .i_prbs_tx_en, .i_tx_data(tx_d), .i_tx_data_valid(tx_v), .o_tx_clk, .o_mod_valid,
    .o_mod_bit, .o_mod_idle, .i_mod_ready, .i_dem_valid, .i_dem_bit, .o_rx_clk,
    .o_rx_data, .o_sync, .o_byte_err, .o_seq_start, .o_err_count);
  spbt_user_model mdl (.i_core_clk, .i_nrst, .i_frame_en, .i_tx_clk(o_tx_clk),
    .o_tx_data(tx_d), .o_tx_data_valid(tx_v));
  always #10 i_core_clk = ~i_core_clk;
  task automatic chk(input string n, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge i_core_clk) if (++cycles == 90000) begin
    miscompares++;
    end_of_test();
  end
  // Each accepted head is compared with the user's slot or the reference sequence.
  always @(posedge i_core_clk) begin
    // Shown rx data is the last bit delivered before the clock's falling edge.
    if (prx && !o_rx_clk) chk("rx_data", rxe, o_rx_data);
    rxe = rxh;
    rxh = !i_nrst ? 1'b0 : i_dem_valid ? i_dem_bit : rxh;
    prx = o_rx_clk && i_nrst;
    gbyte += nbits > 512 && o_byte_err === 1'b1;
    gstart += nbits > 512 && o_seq_start === 1'b1;
    acc = i_nrst && o_mod_valid && i_mod_ready;
    if (acc) begin
      ntx++;
      if (i_prbs_tx_en) begin
        e = gen[10] ^ gen[8];
        gen = {gen[9:0], e};
        chk("mod_bit", e, o_mod_bit);
        chk("mod_idle", 0, o_mod_idle);
      end else begin
        v = mdl.q.pop_front();
        chk("mod_bit", v == 1, o_mod_bit);
        chk("mod_idle", v == 2, o_mod_idle);
      end
      // Flips late in the run give the error counter known work.
      lb = o_mod_bit ^ (ntx > 2000 && ntx % 100 == 50);
    end
  end
  // Accepted bits loop back to the checker; the reference checker runs beside it.
  always @(negedge i_core_clk) begin
    i_dem_valid <= acc;
    i_dem_bit <= lb;
    i_mod_ready <= !stall && $random(seed) % 4 != 0;
    if (acc && i_prbs_tx_en) begin
      nbits++;
      e = nbits > 11 && lb != (hist[10] ^ hist[8]);
      hist = {hist[9:0], lb};
      nerr += e;
      berr |= e;
      if (nbits % 8 == 0) begin
        nbyte += berr && nbits > 512;
        berr = 0;
      end
      nstart += nbits > 512 && hist == 11'h7FF;
      if (nbits % 1000 == 0) begin
        wcnt = nerr;
        nerr = 0;
        due = 4;
      end
    end
    if (due > 0 && --due == 0) begin
      chk("err_count", wcnt, o_err_count);
      chk("sync", 1, o_sync);
    end
  end
  task automatic run(input logic fr, pr, input int n);
    i_frame_en = fr;
    i_prbs_tx_en = pr;
    i_nrst = 1'b0;
    repeat (5) @(negedge i_core_clk);
    i_nrst = 1'b1;
    gen = 11'h7FF;
    ntx = 0;
    // The reference checker restarts with the design's checker.
    nbits = 0;
    nerr = 0;
    berr = 0;
    while (ntx < n) @(negedge i_core_clk);
  endtask
  initial begin
    run(0, 0, 60);
    stall = 1;
    repeat (60) @(negedge i_core_clk);
    chk("tx_clk", 0, o_tx_clk);
    chk("mod_valid", 1, o_mod_valid);
    stall = 0;
    while (ntx < 300) @(negedge i_core_clk);
    chk("sync", 0, o_sync);
    $display("test unframed done");
    run(1, 0, 300);
    $display("test framed done");
    run(0, 1, 4100);
    chk("seq_start", nstart, gstart);
    chk("byte_err", nbyte, gbyte);
    $display("test sequence done");
    end_of_test();
  end
endmodule
`default_nettype wire
